// ### dtio_code_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dtio_code_mem (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// clear to defaults
	input wire logic clr,
	// write port
	input wire logic we,
	input wire logic [dtio_pkg::MEM_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// register side read port
	input wire logic [dtio_pkg::MEM_AW-1:0] raddr_a,
	output logic [7:0] rdata_a,
	// core side read port
	input wire logic [dtio_pkg::MEM_AW-1:0] raddr_b,
	output logic [7:0] rdata_b
);
	import dtio_pkg::*;

	logic [7:0] mem_r [MEM_DEPTH];

	// storage, clear wins over a write
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < MEM_DEPTH; i++) begin
			if (!rst_n || clr) begin
				mem_r[i] <= RST_CODE;
			end else if (we && waddr == MEM_AW'(i)) begin
				mem_r[i] <= wdata;
			end
		end
	end

	// registered read ports
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_a <= RST_CODE;
			rdata_b <= RST_CODE;
		end else begin
			rdata_a <= mem_r[raddr_a];
			rdata_b <= mem_r[raddr_b];
		end
	end
endmodule
`default_nettype wire

// ### dtio_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dtio_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// terminals and drive core
	input wire dtio_pkg::dtio_out_s term_out,
	input wire dtio_pkg::dtio_cond_s cond,
	input wire logic fwd_run_req,
	input wire logic motor_run_fwd,
	input wire logic aout_two_voltage_mode,
	input wire logic [7:0] aout_one_bias_trim
);
	import dtio_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// apb answer timing
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	one_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state wrong");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
	// relay one follows its conditions one edge later; relay two and oc two are checked to drop one edge later
	rly1_both_a: assert property (cond.relay_one_main && cond.relay_one_aux |=> term_out.relay_one)
		else $error("relay one not on");
	rly1_none_a: assert property (!cond.relay_one_main && !cond.relay_one_aux |=> !term_out.relay_one)
		else $error("relay one not off");
	oc2_off_a: assert property (!cond.oc_two_a && !cond.oc_two_b |=> !term_out.oc_output_two)
		else $error("oc two not off");
	rly2_off_a: assert property (!cond.relay_two_main && !cond.relay_two_aux |=> !term_out.relay_two)
		else $error("relay two not off");
	// run output needs a request
	run_gate_a: assert property (!fwd_run_req |=> !motor_run_fwd) else $error("run without request");
	// settings move only on writes
	bias_keep_a: assert property ($changed(aout_one_bias_trim) |-> $past(pready && pwrite && paddr == OFS_BIAS))
		else $error("bias trim moved");
	aout2_mode_a: assert property ($changed(aout_two_voltage_mode) |-> $past(pready && pwrite))
		else $error("aout two mode moved");
endmodule
bind dtio_terminal_logic dtio_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.term_out(term_out), .cond(cond), .fwd_run_req(fwd_run_req), .motor_run_fwd(motor_run_fwd),
	.aout_two_voltage_mode(aout_two_voltage_mode), .aout_one_bias_trim(aout_one_bias_trim));
`default_nettype wire

// ### dtio_pkg.sv
`default_nettype none
package dtio_pkg;
	// clock and time units
	localparam int CLK_HZ = 200_000_000;
	localparam int FILTER_UNIT_US = 2000;
	localparam int FILTER_UNIT_CYCLES = (CLK_HZ / 1_000_000) * FILTER_UNIT_US;
	localparam int DELAY_UNIT_MS = 100;
	localparam int DELAY_UNIT_CYCLES = (CLK_HZ / 1000) * DELAY_UNIT_MS;

	// setting limits
	localparam logic [7:0] FILTER_MAX = 8'hc8;
	localparam logic [9:0] DELAY_MAX = 10'h258;

	// register byte offsets
	localparam logic [11:0] OFS_POLARITY = 12'h000;
	localparam logic [11:0] OFS_FILTER = 12'h004;
	localparam logic [11:0] OFS_CTRL = 12'h008;
	localparam logic [11:0] OFS_OC2_DELAY = 12'h00c;
	localparam logic [11:0] OFS_RLY2_DELAY = 12'h010;
	localparam logic [11:0] OFS_STATUS = 12'h014;
	localparam logic [11:0] OFS_RESTORE = 12'h018;
	localparam logic [11:0] OFS_BIAS = 12'h01c;
	localparam logic [11:0] OFS_CODE_BASE = 12'h020;
	localparam logic [11:0] OFS_CODE_LAST = 12'h03c;

	// control register bit positions
	localparam int CTRL_RLY1_OR_BIT = 0;
	localparam int CTRL_PWRUP_RUN_BIT = 1;
	localparam int CTRL_OC2_OR_BIT = 2;
	localparam int CTRL_RLY2_OR_BIT = 3;
	localparam int CTRL_AO2_VOLT_BIT = 4;
	localparam int CTRL_W = 5;

	// status register field positions
	localparam int STAT_LEVEL_LSB = 0;
	localparam int STAT_FUNC_LSB = 8;
	localparam int STAT_OUT_LSB = 16;
	localparam int STAT_RUN_LSB = 19;

	// reset values
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_FILTER = 8'h00;
	localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;
	localparam logic [9:0] RST_DELAY = 10'h000;
	localparam logic [7:0] RST_BIAS = 8'h7e;
	localparam logic [7:0] RST_CODE = 8'h00;
	localparam logic [31:0] RESTORE_CMD = 32'h0000_0001;

	// function code memory
	localparam int MEM_DEPTH = 8;
	localparam int MEM_AW = 3;
	localparam logic [MEM_AW-1:0] CODE_IN5 = 3'h0;
	localparam logic [MEM_AW-1:0] CODE_IN8 = 3'h3;
	localparam logic [MEM_AW-1:0] CODE_RLY2_MAIN = 3'h4;
	localparam logic [MEM_AW-1:0] CODE_RLY2_AUX = 3'h5;
	localparam logic [7:0] CODE_INPUT_MAX = 8'h4b;

	// function conditions from the drive core
	typedef struct packed {
		logic relay_one_main;
		logic relay_one_aux;
		logic relay_two_main;
		logic relay_two_aux;
		logic oc_two_a;
		logic oc_two_b;
	} dtio_cond_s;

	// terminal outputs
	typedef struct packed {
		logic oc_output_two;
		logic relay_two;
		logic relay_one;
	} dtio_out_s;

	// run interlock state
	typedef enum logic [0:0] {
		RUN_LOCKED,
		RUN_ARMED
	} dtio_run_e;
endpackage
`default_nettype wire

// ### dtio_switch_bank.sv
`timescale 1ns/1ps
`default_nettype none
module dtio_switch_bank (
	// clock
	input wire logic core_clk,
	// commanded contact states
	input wire logic [7:0] want,
	// terminal wires
	output logic [7:0] pins
);
	// contacts move just after a core_clk edge, in step with the sampler
	initial pins = 8'h00;
	always @(posedge core_clk) begin
		pins <= want;
	end
endmodule
`default_nettype wire

// ### dtio_terminal_logic.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: eight-bit polarity register, bit 0 for input one up to bit 7 for input eight.
// R2: polarity bit 0 makes the function active while terminal is off.
// R3: input filter time set in 2 ms units, range 0 to 200.
// R4: new level accepted only after stable for filter time; zero passes straight.
// R5: relay one combine select 0: energise when main and aux both true.
// R6: relay one combine select 1: energise when main or aux true.
// R7: power-up detect 0: run held off until run input opened and closed again.
// R8: power-up detect 1: run starts at power-up when run input is on.
// R9: open-collector two combine select 0 drives AND of its two conditions.
// R10: open-collector two activation delayed by 0 to 60.0 seconds.
// R11: relay two closing delayed 0 to 60.0 seconds after condition true.
// R12: one bit selects AND or OR for relay two conditions.
// R13: relay two main and aux function codes held, each 0 to 255.
// R14: function codes 0 to 75 held for logic inputs five to eight; the code stores any value 0 to 255 there, unclamped.
// R15: analog output two type bit: 0 current, 1 voltage.
// R16: restore-defaults command 1 leaves the output bias trim unchanged.
module dtio_terminal_logic #(
	parameter int FILTER_TICK = dtio_pkg::FILTER_UNIT_CYCLES,
	parameter int DELAY_TICK = dtio_pkg::DELAY_UNIT_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// terminal pins
	input wire logic [7:0] logic_inputs_one_to_eight,
	output dtio_pkg::dtio_out_s term_out,
	// drive core side
	input wire dtio_pkg::dtio_cond_s cond,
	input wire logic fwd_run_req,
	input wire logic rev_run_req,
	input wire logic [dtio_pkg::MEM_AW-1:0] code_sel,
	output logic [7:0] code_q,
	output logic [7:0] input_function_active,
	output logic motor_run_fwd,
	output logic motor_run_rev,
	// analog settings
	output logic aout_two_voltage_mode,
	output logic [7:0] aout_one_bias_trim
);
	import dtio_pkg::*;

	// two conditions joined by and or or
	function automatic logic combine(input logic main_c, input logic aux_c, input logic or_sel);
		combine = or_sel ? (main_c | aux_c) : (main_c & aux_c);
	endfunction

	// word decode of an offset
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
		hit = (addr == ofs);
	endfunction

	logic [7:0] input_polarity_select_r;
	logic [7:0] input_filter_time_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic [9:0] oc_output_two_delay_r;
	logic [9:0] relay_two_close_delay_r;
	logic [7:0] bias_r;
	logic ack_r;
	logic [31:0] prdata_r;
	logic slverr_r;
	logic wr_en;
	logic restore;
	logic code_hit;
	logic mapped;
	logic [31:0] status_w;
	logic [31:0] rd_mux;
	logic [7:0] mem_rdata;
	logic [7:0] s1_r, s2_r, s3_r;
	logic [7:0] level_r;
	logic [7:0] fcnt_r [8];
	logic [31:0] ftick_cnt_r;
	logic ftick;
	logic [31:0] dtick_cnt_r;
	logic dtick;
	logic [1:0] dly_req;
	logic [9:0] dly_set [2];
	logic [9:0] dcnt_r [2];
	logic [1:0] dly_out_r;
	logic relay_one_r;
	dtio_run_e run_r;

	// apb decode
	assign code_hit = (paddr >= OFS_CODE_BASE) && (paddr <= OFS_CODE_LAST);
	assign mapped = (paddr[1:0] == 2'h0) && (code_hit || hit(paddr, OFS_POLARITY) || hit(paddr, OFS_FILTER)
		|| hit(paddr, OFS_CTRL) || hit(paddr, OFS_OC2_DELAY) || hit(paddr, OFS_RLY2_DELAY)
		|| hit(paddr, OFS_STATUS) || hit(paddr, OFS_RESTORE) || hit(paddr, OFS_BIAS));
	assign wr_en = psel && penable && pwrite && ack_r && mapped;
	assign restore = wr_en && hit(paddr, OFS_RESTORE) && (pwdata == RESTORE_CMD);
	assign pready = psel && penable && ack_r;
	assign prdata = prdata_r;
	assign pslverr = pready && slverr_r;

	// one wait cycle: answer on the second access cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= psel && penable && !ack_r;
		end
	end

	// read data and error captured in the first access cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else if (psel && penable && !ack_r) begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
			slverr_r <= !mapped;
		end
	end

	// status word, reads the block's live state
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[STAT_LEVEL_LSB +: 8] = level_r;
		status_w[STAT_FUNC_LSB +: 8] = input_function_active;
		status_w[STAT_OUT_LSB +: 3] = term_out;
		status_w[STAT_RUN_LSB] = (run_r == RUN_ARMED);
	end

	// read multiplexer
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (code_hit) begin
			rd_mux[7:0] = mem_rdata;
		end else if (hit(paddr, OFS_POLARITY)) begin
			rd_mux[7:0] = input_polarity_select_r;
		end else if (hit(paddr, OFS_FILTER)) begin
			rd_mux[7:0] = input_filter_time_r;
		end else if (hit(paddr, OFS_CTRL)) begin
			rd_mux[CTRL_W-1:0] = ctrl_r;
		end else if (hit(paddr, OFS_OC2_DELAY)) begin
			rd_mux[9:0] = oc_output_two_delay_r;
		end else if (hit(paddr, OFS_RLY2_DELAY)) begin
			rd_mux[9:0] = relay_two_close_delay_r;
		end else if (hit(paddr, OFS_STATUS)) begin
			rd_mux = status_w;
		end else if (hit(paddr, OFS_BIAS)) begin
			rd_mux[7:0] = bias_r;
		end
	end

	// configuration registers, restore returns them to defaults
	always_ff @(posedge core_clk) begin
		if (!rst_n || restore) begin
			input_polarity_select_r <= RST_POLARITY; // R1
			input_filter_time_r <= RST_FILTER;
			ctrl_r <= RST_CTRL;
			oc_output_two_delay_r <= RST_DELAY;
			relay_two_close_delay_r <= RST_DELAY;
		end else if (wr_en) begin
			if (hit(paddr, OFS_POLARITY)) begin
				input_polarity_select_r <= pwdata[7:0]; // R1
			end
			if (hit(paddr, OFS_FILTER)) begin
				input_filter_time_r <= (pwdata[7:0] > FILTER_MAX) ? FILTER_MAX : pwdata[7:0]; // R3
			end
			if (hit(paddr, OFS_CTRL)) begin
				ctrl_r <= pwdata[CTRL_W-1:0]; // R12
			end
			if (hit(paddr, OFS_OC2_DELAY)) begin
				oc_output_two_delay_r <= (pwdata[9:0] > DELAY_MAX) ? DELAY_MAX : pwdata[9:0]; // R10
			end
			if (hit(paddr, OFS_RLY2_DELAY)) begin
				relay_two_close_delay_r <= (pwdata[9:0] > DELAY_MAX) ? DELAY_MAX : pwdata[9:0]; // R11
			end
		end
	end

	// bias trim survives restore
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bias_r <= RST_BIAS;
		end else if (wr_en && hit(paddr, OFS_BIAS)) begin
			bias_r <= pwdata[7:0]; // R16
		end
	end

	assign aout_one_bias_trim = bias_r;
	assign aout_two_voltage_mode = ctrl_r[CTRL_AO2_VOLT_BIT]; // R15

	// function codes for inputs five to eight and relay two
	dtio_code_mem u_code_mem (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clr(restore),
		.we(wr_en && code_hit), // R13 R14
		.waddr(paddr[MEM_AW+1:2]),
		.wdata(pwdata[7:0]),
		.raddr_a(paddr[MEM_AW+1:2]),
		.rdata_a(mem_rdata),
		.raddr_b(code_sel),
		.rdata_b(code_q)
	);

	// filter time base, one tick per unit
	always_ff @(posedge core_clk) begin
		if (!rst_n || ftick) begin
			ftick_cnt_r <= 32'h0000_0000;
		end else begin
			ftick_cnt_r <= ftick_cnt_r + 32'h0000_0001;
		end
	end
	assign ftick = (ftick_cnt_r == 32'(FILTER_TICK - 1));

	// delay time base, one tick per tenth of a second
	always_ff @(posedge core_clk) begin
		if (!rst_n || dtick) begin
			dtick_cnt_r <= 32'h0000_0000;
		end else begin
			dtick_cnt_r <= dtick_cnt_r + 32'h0000_0001;
		end
	end
	assign dtick = (dtick_cnt_r == 32'(DELAY_TICK - 1));

	// pin synchroniser, three stages
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_r <= 8'h00;
			s2_r <= 8'h00;
			s3_r <= 8'h00;
		end else begin
			s1_r <= logic_inputs_one_to_eight;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// per-input filter and polarity
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_in
			// accept a level only once it held for the filter time
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					level_r[gi] <= 1'b0;
					fcnt_r[gi] <= 8'h00;
				end else if (s2_r[gi] != s3_r[gi] || s3_r[gi] == level_r[gi]) begin
					fcnt_r[gi] <= 8'h00; // R4
				end else if (input_filter_time_r == 8'h00) begin
					level_r[gi] <= s3_r[gi]; // R4
				end else if (ftick) begin
					if (fcnt_r[gi] >= input_filter_time_r) begin // whole units elapsed, never one short
						level_r[gi] <= s3_r[gi]; // R3
						fcnt_r[gi] <= 8'h00;
					end else begin
						fcnt_r[gi] <= fcnt_r[gi] + 8'h01;
					end
				end
			end

			// bit 0 inverts, bit 1 passes the terminal level
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					input_function_active[gi] <= 1'b0;
				end else begin
					input_function_active[gi] <= input_polarity_select_r[gi] ? level_r[gi] : !level_r[gi]; // R2
				end
			end
		end
	endgenerate

	// relay one has no delay
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			relay_one_r <= 1'b0;
		end else begin
			relay_one_r <= combine(cond.relay_one_main, cond.relay_one_aux, ctrl_r[CTRL_RLY1_OR_BIT]); // R5 R6
		end
	end

	// delayed channels: 0 relay two, 1 open-collector two
	assign dly_req[0] = combine(cond.relay_two_main, cond.relay_two_aux, ctrl_r[CTRL_RLY2_OR_BIT]); // R12
	assign dly_req[1] = combine(cond.oc_two_a, cond.oc_two_b, ctrl_r[CTRL_OC2_OR_BIT]); // R9
	assign dly_set[0] = relay_two_close_delay_r;
	assign dly_set[1] = oc_output_two_delay_r;

	genvar gd;
	generate
		for (gd = 0; gd < 2; gd++) begin : g_dly
			// on after the set delay, off at once
			always_ff @(posedge core_clk) begin
				if (!rst_n || !dly_req[gd]) begin
					dly_out_r[gd] <= 1'b0;
					dcnt_r[gd] <= 10'h000;
				end else if (dly_set[gd] == 10'h000) begin
					dly_out_r[gd] <= 1'b1;
				end else if (!dly_out_r[gd] && dtick) begin
					if (dcnt_r[gd] >= dly_set[gd]) begin // full delay elapsed before closing
						dly_out_r[gd] <= 1'b1; // R10 R11
					end else begin
						dcnt_r[gd] <= dcnt_r[gd] + 10'h001;
					end
				end
			end
		end
	endgenerate

	assign term_out.relay_one = relay_one_r;
	assign term_out.relay_two = dly_out_r[0];
	assign term_out.oc_output_two = dly_out_r[1];

	// power-up run interlock
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_r <= RUN_LOCKED;
		end else begin
			case (run_r)
				RUN_LOCKED: begin
					if (ctrl_r[CTRL_PWRUP_RUN_BIT]) begin
						run_r <= RUN_ARMED; // R8
					end else if (!fwd_run_req && !rev_run_req) begin
						run_r <= RUN_ARMED; // R7
					end
				end
				RUN_ARMED: begin
					run_r <= RUN_ARMED;
				end
				default: begin
					run_r <= RUN_LOCKED;
				end
			endcase
		end
	end

	// run commands pass only once armed
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			motor_run_fwd <= 1'b0;
			motor_run_rev <= 1'b0;
		end else begin
			motor_run_fwd <= (run_r == RUN_ARMED) && fwd_run_req; // R7 R8
			motor_run_rev <= (run_r == RUN_ARMED) && rev_run_req;
		end
	end
endmodule
`default_nettype wire

// ### dtio_terminal_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module dtio_terminal_logic_test;
	import dtio_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] want = 8'h00, pins, code_q, act, trim;
	dtio_out_s term_out;
	dtio_cond_s cond = '0;
	logic fwd = 1'b1, rev = 1'b0, run_f, run_r, vmode;
	logic [2:0] code_sel = 3'h0;
	int bad_count = 0, compares = 0, cyc = 0;
	// 200 mhz clock
	always #2.5 core_clk = ~core_clk;
	dtio_terminal_logic #(.FILTER_TICK(4), .DELAY_TICK(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .logic_inputs_one_to_eight(pins),
		.term_out(term_out), .cond(cond), .fwd_run_req(fwd), .rev_run_req(rev), .code_sel(code_sel),
		.code_q(code_q), .input_function_active(act), .motor_run_fwd(run_f), .motor_run_rev(run_r),
		.aout_two_voltage_mode(vmode), .aout_one_bias_trim(trim));
	dtio_switch_bank sw_u (.core_clk(core_clk), .want(want), .pins(pins));
	task automatic results();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		cycles(10);
		rst_n <= 1'b1;
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// pready or else the hang guard ends this wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask
	initial begin
		do_reset();
		// reset values, run held off while the request stays closed
		rchk(OFS_POLARITY, 32'h0);
		rchk(OFS_FILTER, 32'h0);
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_BIAS, 32'h7e);
		chk(run_f, 1'b0);
		bus(12'h040, 1'b0, 32'h0);
		chk(err, 1'b1);
		bus(12'h006, 1'b1, 32'h1);
		chk(err, 1'b1);
		// open and re-close the run contact
		fwd <= 1'b0;
		cycles(3);
		fwd <= 1'b1;
		cycles(3);
		chk(run_f, 1'b1);
		// polarity per terminal, filter off
		wr(OFS_POLARITY, 32'ha5);
		rchk(OFS_POLARITY, 32'ha5);
		want <= 8'h0f;
		cycles(10);
		chk(act, 8'h55);
		rchk(OFS_STATUS, 32'h0008550f);
		// filter clamp, glitch rejection, then a real change
		wr(OFS_FILTER, 32'hff);
		rchk(OFS_FILTER, 32'hc8);
		wr(OFS_FILTER, 32'h3);
		want <= 8'h0e;
		cycles(5);
		want <= 8'h0f;
		cycles(30);
		chk(act, 8'h55);
		want <= 8'h0e;
		cycles(6);
		chk(act, 8'h55);
		cycles(20);
		chk(act, 8'h54);
		wr(OFS_FILTER, 32'h0);
		// every combine mode against every condition pair
		for (int s = 0; s < 2; s++) begin
			wr(OFS_CTRL, s ? 32'h0d : 32'h0);
			for (int c = 0; c < 4; c++) begin
				cond <= {c[1], c[0], c[1], c[0], c[1], c[0]};
				cycles(4);
				chk(term_out, s ? {3{|c[1:0]}} : {3{&c[1:0]}});
			end
		end
		// delayed outputs
		wr(OFS_CTRL, 32'h0);
		cond <= '0;
		wr(OFS_OC2_DELAY, 32'h2);
		wr(OFS_RLY2_DELAY, 32'h5);
		cond <= 6'h0f;
		cycles(8);
		chk(term_out, 3'b000);
		cycles(7);
		chk(term_out, 3'b100);
		cycles(5);
		chk(term_out, 3'b100);
		cycles(7);
		chk(term_out, 3'b110);
		// analog type, codes, restore keeps the trim
		wr(OFS_CTRL, 32'h10);
		wr(OFS_BIAS, 32'h33);
		wr(OFS_CODE_BASE + 12'h010, 32'hff);
		wr(OFS_CODE_BASE, 32'h4b);
		rchk(OFS_CODE_BASE + 12'h010, 32'hff);
		rchk(OFS_CODE_BASE, 32'h4b);
		code_sel <= CODE_RLY2_MAIN;
		cycles(2);
		chk(code_q, 8'hff);
		chk(vmode, 1'b1);
		wr(OFS_RESTORE, 32'h1);
		rchk(OFS_BIAS, 32'h33);
		rchk(OFS_POLARITY, 32'h0);
		rchk(OFS_CODE_BASE, 32'h0);
		chk(trim, 8'h33);
		chk(vmode, 1'b0);
		// power-up with detection enabled runs at once
		rev <= 1'b1;
		do_reset();
		wr(OFS_CTRL, 32'h2);
		cycles(3);
		chk(run_r, 1'b1);
		chk(trim, 8'h7e);
		results();
	end
endmodule
`default_nettype wire
